// [pkg/usbreg_pkg.sv]
// Constants and types shared by the endpoint-zero request decoder.
// Assumes a USB core that hands over decoded SETUP fields and data bytes.
package usbreg_pkg;

    // Request types and codes
    localparam logic [7:0] TYPE_VEN_WR = 8'h40;
    localparam logic [7:0] TYPE_VEN_RD = 8'hc0;
    localparam logic [7:0] TYPE_DEV_IN = 8'h80;
    localparam logic [7:0] TYPE_CDC_OUT = 8'h21;
    localparam logic [7:0] TYPE_CDC_IN = 8'ha1;
    localparam logic [7:0] REQ_VEN_WR = 8'h00;
    localparam logic [7:0] REQ_VEN_RD = 8'h01;
    localparam logic [7:0] REQ_GET_STATUS = 8'h00;
    localparam logic [7:0] REQ_SET_LC = 8'h20;
    localparam logic [7:0] REQ_GET_LC = 8'h21;
    localparam logic [7:0] REQ_SET_CLS = 8'h22;
    localparam logic [7:0] REQ_BREAK = 8'h23;

    // Block numbers
    localparam logic [7:0] BLK_UART = 8'h00;
    localparam logic [7:0] BLK_MGR = 8'h04;
    localparam logic [7:0] BLK_EEP = 8'h65;
    localparam logic [7:0] BLK_CUST = 8'h66;

    // Register offsets
    localparam logic [7:0] OFS_UART_EN = 8'h03;
    localparam logic [7:0] OFS_UART_MAX = 8'h1f;
    localparam logic [7:0] OFS_GATE = 8'h10;
    localparam logic [7:0] OFS_RX_FLUSH = 8'h18;
    localparam logic [7:0] OFS_TX_FLUSH = 8'h1c;
    localparam logic [7:0] OFS_CUST_WIDE = 8'h00;
    localparam logic [7:0] OFS_CUST_LOWLAT = 8'h01;
    localparam logic [7:0] OFS_CUST_IRQPKT = 8'h02;

    // Field positions
    localparam int GATE_TX_BIT = 0;
    localparam int GATE_RX_BIT = 1;
    localparam int EN_TX_BIT = 0;
    localparam int EN_RX_BIT = 1;
    localparam int CLS_DTR_BIT = 0;
    localparam int CLS_RTS_BIT = 1;
    localparam int CUST_BIT = 0;

    // Reset values
    localparam logic [1:0] GATE_RST = 2'h0;
    localparam logic [1:0] UART_EN_RST = 2'h0;

    // Lengths and storage layout
    localparam logic [15:0] LC_LEN = 16'h0007;
    localparam logic [15:0] STATUS_LEN = 16'h0002;
    localparam logic [5:0] LC_BASE = 6'h20;
    localparam logic [15:0] BREAK_FOREVER = 16'hffff;

    // Timing: break duration unit is one millisecond
    localparam int CLK_PERIOD_NS = 50;
    localparam int BREAK_UNIT_NS = 1000000;
    localparam int BREAK_UNIT_CYC = BREAK_UNIT_NS / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        K_NONE, K_VWR, K_VRD, K_STAT, K_SLC, K_GLC, K_CLS, K_BRK
    } kind_t;

    typedef enum logic [2:0] {
        S_IDLE, S_FETCH, S_LOAD, S_SEND, S_RECV
    } state_t;

endpackage

// [rtl/reg_store.sv]
// Small byte store for the UART group and the line coding bytes.
// Read data is registered; unwritten entries read as zero after reset.
`timescale 1ns/10ps
module reg_store (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic we,
    input wire logic [5:0] waddr,
    input wire logic [7:0] wdata,
    input wire logic [5:0] raddr,
    output logic [7:0] rdata
);
    logic [7:0] mem [64];
    logic [63:0] valid_q;

    // Valid bits stand in for clearing the array, which keeps it a RAM
    always_ff @(posedge sys_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            valid_q <= 64'h0;
            rdata <= 8'h00;
        end else begin
            if (we) begin
                valid_q[waddr] <= 1'b1;
            end
            rdata <= valid_q[raddr] ? mem[raddr] : 8'h00;
        end
    end
endmodule

// [rtl/usb_vendor_register_access.sv]
// Endpoint-zero request decoder: vendor register access and CDC requests.
// Assumes a USB core that delivers SETUP fields, OUT bytes and IN handshake.
`timescale 1ns/10ps
module usb_vendor_register_access #(
    parameter int BREAK_UNIT_CYCLES = usbreg_pkg::BREAK_UNIT_CYC
) (
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic setup_valid,
    input wire logic [7:0] setup_type,
    input wire logic [7:0] setup_req,
    input wire logic [15:0] setup_value,
    input wire logic [15:0] setup_index,
    input wire logic [15:0] setup_length,
    input wire logic out_valid,
    input wire logic [7:0] out_data,
    output logic out_ready,
    output logic in_valid,
    output logic [7:0] in_data,
    input wire logic in_ready,
    output logic ctrl_done,
    output logic ctrl_stall,
    input wire logic self_powered,
    input wire logic remote_wakeup_en,
    output logic eep_wr,
    output logic eep_rd,
    output logic [7:0] eep_addr,
    output logic [7:0] eep_wdata,
    input wire logic [7:0] eep_rdata,
    output logic [1:0] queue_gate,
    output logic rx_queue_flush,
    output logic tx_queue_flush,
    output logic uart_tx_en,
    output logic uart_rx_en,
    output logic wide_mode,
    output logic low_latency,
    output logic irq_packet_en,
    output logic dtr,
    output logic rts,
    output logic break_active
);

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    function automatic logic [5:0] lc_addr(input logic [15:0] i);
        lc_addr = 6'(usbreg_pkg::LC_BASE + i[5:0]);
    endfunction

    wire [7:0] blk = setup_index[15:8];
    wire [7:0] ofs = setup_index[7:0];
    wire blk_ok = (blk == usbreg_pkg::BLK_UART) ||
        (blk == usbreg_pkg::BLK_MGR) || (blk == usbreg_pkg::BLK_EEP) ||
        (blk == usbreg_pkg::BLK_CUST);
    wire is_vwr = setup_type == usbreg_pkg::TYPE_VEN_WR &&
        setup_req == usbreg_pkg::REQ_VEN_WR && setup_length == 16'h0;
    wire is_vrd = setup_type == usbreg_pkg::TYPE_VEN_RD &&
        setup_req == usbreg_pkg::REQ_VEN_RD;
    wire is_stat = setup_type == usbreg_pkg::TYPE_DEV_IN &&
        setup_req == usbreg_pkg::REQ_GET_STATUS &&
        setup_length == usbreg_pkg::STATUS_LEN;
    wire is_slc = setup_type == usbreg_pkg::TYPE_CDC_OUT &&
        setup_req == usbreg_pkg::REQ_SET_LC &&
        setup_length == usbreg_pkg::LC_LEN;
    wire is_glc = setup_type == usbreg_pkg::TYPE_CDC_IN &&
        setup_req == usbreg_pkg::REQ_GET_LC;
    wire is_cls = setup_type == usbreg_pkg::TYPE_CDC_OUT &&
        setup_req == usbreg_pkg::REQ_SET_CLS &&
        setup_length == 16'h0;
    wire is_brk = setup_type == usbreg_pkg::TYPE_CDC_OUT &&
        setup_req == usbreg_pkg::REQ_BREAK;
    wire usbreg_pkg::kind_t kind = is_vwr ? usbreg_pkg::K_VWR :
        is_vrd ? usbreg_pkg::K_VRD : is_stat ? usbreg_pkg::K_STAT :
        is_slc ? usbreg_pkg::K_SLC : is_glc ? usbreg_pkg::K_GLC :
        is_cls ? usbreg_pkg::K_CLS : is_brk ? usbreg_pkg::K_BRK :
        usbreg_pkg::K_NONE;
    wire vendor = is_vwr || is_vrd;
    wire accept = kind != usbreg_pkg::K_NONE && (!vendor || blk_ok);

    // Register writes happen in the SETUP cycle; there is no other path in
    wire wr = setup_valid && is_vwr && accept;
    wire [7:0] wval = setup_value[7:0];
    wire wr_uart = wr && blk == usbreg_pkg::BLK_UART &&
        ofs <= usbreg_pkg::OFS_UART_MAX;
    wire wr_mgr = wr && blk == usbreg_pkg::BLK_MGR;
    wire wr_cust = wr && blk == usbreg_pkg::BLK_CUST;

    ////////////////////////////////////////////////////////////////////////
    // Transfer sequencer

    usbreg_pkg::state_t state_q;
    usbreg_pkg::kind_t kind_q;
    logic [7:0] blk_q, ofs_q;
    logic [15:0] len_q, idx_q;
    logic done_q, stall_q;
    logic [7:0] in_data_q;
    logic [7:0] mem_rdata;

    wire [7:0] rd_ofs = ofs_q + idx_q[7:0];
    wire in_fire = state_q == usbreg_pkg::S_SEND && in_ready;
    wire out_fire = state_q == usbreg_pkg::S_RECV && out_valid &&
        !setup_valid;
    wire [15:0] idx_nx = idx_q + 16'h1;
    wire starts_in = is_vrd || is_stat || is_glc;

    // A new SETUP aborts whatever transfer was in flight
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_q <= usbreg_pkg::S_IDLE;
            kind_q <= usbreg_pkg::K_NONE;
            blk_q <= 8'h00;
            ofs_q <= 8'h00;
            len_q <= 16'h0;
            idx_q <= 16'h0;
            done_q <= 1'b0;
            stall_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            stall_q <= 1'b0;
            if (setup_valid) begin
                kind_q <= kind;
                blk_q <= blk;
                ofs_q <= ofs;
                len_q <= setup_length;
                idx_q <= 16'h0;
                state_q <= usbreg_pkg::S_IDLE;
                if (!accept) begin
                    stall_q <= 1'b1;
                end else if (is_slc) begin
                    state_q <= usbreg_pkg::S_RECV;
                end else if (starts_in && setup_length != 16'h0) begin
                    state_q <= usbreg_pkg::S_FETCH;
                end else begin
                    done_q <= 1'b1;
                end
            end else begin
                case (state_q)
                    usbreg_pkg::S_FETCH: state_q <= usbreg_pkg::S_LOAD;
                    usbreg_pkg::S_LOAD: state_q <= usbreg_pkg::S_SEND;
                    usbreg_pkg::S_SEND: begin
                        if (in_ready) begin
                            idx_q <= idx_nx;
                            if (idx_nx == len_q) begin
                                state_q <= usbreg_pkg::S_IDLE;
                                done_q <= 1'b1;
                            end else begin
                                state_q <= usbreg_pkg::S_FETCH;
                            end
                        end
                    end
                    usbreg_pkg::S_RECV: begin
                        if (out_valid) begin
                            idx_q <= idx_nx;
                            if (idx_nx == usbreg_pkg::LC_LEN) begin
                                state_q <= usbreg_pkg::S_IDLE;
                                done_q <= 1'b1;
                            end
                        end
                    end
                    default: state_q <= usbreg_pkg::S_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte store and read selection

    wire mem_we = wr_uart || out_fire;
    wire [5:0] mem_waddr = out_fire ? lc_addr(idx_q) : ofs[5:0];
    wire [7:0] mem_wdata = out_fire ? out_data : wval;
    wire [5:0] mem_raddr = kind_q == usbreg_pkg::K_GLC ? lc_addr(idx_q) :
        {1'b0, rd_ofs[4:0]};

    reg_store u_store (
        .sys_clk(sys_clk),
        .srst(srst),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    logic [1:0] gate_q, uart_en_q;
    logic wide_q, lowlat_q, irqpkt_q;

    wire [7:0] mgr_rd = rd_ofs == usbreg_pkg::OFS_GATE ?
        {6'h00, gate_q} : 8'h00;
    wire [7:0] cust_rd = rd_ofs == usbreg_pkg::OFS_CUST_WIDE ?
        {7'h00, wide_q} : rd_ofs == usbreg_pkg::OFS_CUST_LOWLAT ?
        {7'h00, lowlat_q} : rd_ofs == usbreg_pkg::OFS_CUST_IRQPKT ?
        {7'h00, irqpkt_q} : 8'h00;
    wire [7:0] uart_rd = rd_ofs <= usbreg_pkg::OFS_UART_MAX ?
        mem_rdata : 8'h00;
    wire [7:0] vrd_byte = blk_q == usbreg_pkg::BLK_UART ? uart_rd :
        blk_q == usbreg_pkg::BLK_MGR ? mgr_rd :
        blk_q == usbreg_pkg::BLK_EEP ? eep_rdata : cust_rd;
    wire [7:0] stat_byte = idx_q == 16'h0 ?
        {6'h00, remote_wakeup_en, self_powered} : 8'h00;
    wire [7:0] in_byte = kind_q == usbreg_pkg::K_STAT ? stat_byte :
        kind_q == usbreg_pkg::K_GLC ? mem_rdata : vrd_byte;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            in_data_q <= 8'h00;
        end else if (state_q == usbreg_pkg::S_LOAD) begin
            in_data_q <= in_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers and modem lines

    logic rx_fl_q, tx_fl_q, dtr_q, rts_q;
    wire rx_fl_d = wr_mgr && ofs == usbreg_pkg::OFS_RX_FLUSH &&
        wval != 8'h00;
    wire tx_fl_d = wr_mgr && ofs == usbreg_pkg::OFS_TX_FLUSH &&
        wval != 8'h00;
    wire cls_go = setup_valid && is_cls;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            gate_q <= usbreg_pkg::GATE_RST;
            uart_en_q <= usbreg_pkg::UART_EN_RST;
            {wide_q, lowlat_q, irqpkt_q} <= 3'h0;
            {rx_fl_q, tx_fl_q, dtr_q, rts_q} <= 4'h0;
        end else begin
            rx_fl_q <= rx_fl_d;
            tx_fl_q <= tx_fl_d;
            if (wr_mgr && ofs == usbreg_pkg::OFS_GATE) begin
                gate_q <= wval[1:0];
            end
            if (wr_uart && ofs == usbreg_pkg::OFS_UART_EN) begin
                uart_en_q <= wval[1:0];
            end
            if (wr_cust && ofs == usbreg_pkg::OFS_CUST_WIDE) begin
                wide_q <= wval[usbreg_pkg::CUST_BIT];
            end
            if (wr_cust && ofs == usbreg_pkg::OFS_CUST_LOWLAT) begin
                lowlat_q <= wval[usbreg_pkg::CUST_BIT];
            end
            if (wr_cust && ofs == usbreg_pkg::OFS_CUST_IRQPKT) begin
                irqpkt_q <= wval[usbreg_pkg::CUST_BIT];
            end
            if (cls_go) begin
                dtr_q <= setup_value[usbreg_pkg::CLS_DTR_BIT];
                rts_q <= setup_value[usbreg_pkg::CLS_RTS_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Break timer: 0xFFFF holds the break until a new break request ends it

    logic [15:0] brk_left_q;
    logic brk_hold_q;
    logic [23:0] tick_q;
    wire tick_end = tick_q == 24'(BREAK_UNIT_CYCLES - 1);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            brk_left_q <= 16'h0;
            brk_hold_q <= 1'b0;
            tick_q <= 24'h0;
        end else if (setup_valid && is_brk) begin
            brk_left_q <= setup_value;
            brk_hold_q <= setup_value == usbreg_pkg::BREAK_FOREVER;
            tick_q <= 24'h0;
        end else if (brk_left_q != 16'h0) begin
            tick_q <= tick_end ? 24'h0 : tick_q + 24'h1;
            if (tick_end && !brk_hold_q) begin
                brk_left_q <= brk_left_q - 16'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign out_ready = state_q == usbreg_pkg::S_RECV;
    assign in_valid = state_q == usbreg_pkg::S_SEND;
    assign in_data = in_data_q;
    assign ctrl_done = done_q;
    assign ctrl_stall = stall_q;
    // EEPROM must present read data on the cycle after eep_rd
    assign eep_wr = wr && blk == usbreg_pkg::BLK_EEP;
    assign eep_rd = state_q == usbreg_pkg::S_FETCH && kind_q ==
        usbreg_pkg::K_VRD && blk_q == usbreg_pkg::BLK_EEP;
    assign eep_addr = eep_wr ? ofs : rd_ofs;
    assign eep_wdata = wval;
    assign queue_gate = gate_q;
    assign rx_queue_flush = rx_fl_q;
    assign tx_queue_flush = tx_fl_q;
    assign uart_tx_en = uart_en_q[usbreg_pkg::EN_TX_BIT];
    assign uart_rx_en = uart_en_q[usbreg_pkg::EN_RX_BIT];
    assign wide_mode = wide_q;
    assign low_latency = lowlat_q;
    assign irq_packet_en = irqpkt_q;
    assign dtr = dtr_q;
    assign rts = rts_q;
    assign break_active = brk_left_q != 16'h0;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    a_gate_write: assert property (@(posedge sys_clk) disable iff (srst)
        wr_mgr && ofs == usbreg_pkg::OFS_GATE |=>
        queue_gate == $past(setup_value[1:0]))
        else $error("gate register not updated");
    a_flush_cause: assert property (@(posedge sys_clk) disable iff (srst)
        rx_queue_flush || tx_queue_flush |-> $past(wr_mgr) &&
        $past(setup_value[7:0]) != 8'h00)
        else $error("flush without non-zero write");
    a_flush_rx: assert property (@(posedge sys_clk) disable iff (srst)
        setup_valid && is_vwr && blk == usbreg_pkg::BLK_MGR &&
        ofs == usbreg_pkg::OFS_RX_FLUSH && setup_value[7:0] != 8'h00 |=>
        rx_queue_flush && !tx_queue_flush)
        else $error("rx flush missing");
    a_bad_stall: assert property (@(posedge sys_clk) disable iff (srst)
        setup_valid && (kind == usbreg_pkg::K_NONE || (vendor && !blk_ok))
        |=> ctrl_stall && !ctrl_done)
        else $error("unsupported request not stalled");
    a_uart_enable: assert property (@(posedge sys_clk) disable iff (srst)
        wr_uart && ofs == usbreg_pkg::OFS_UART_EN |=>
        uart_tx_en == $past(setup_value[0]) &&
        uart_rx_en == $past(setup_value[1]))
        else $error("uart enable not updated");
    a_line_state: assert property (@(posedge sys_clk) disable iff (srst)
        cls_go |=> dtr == $past(setup_value[0]) && rts == $past(setup_value[1]))
        else $error("control lines not driven");
    a_break_run: assert property (@(posedge sys_clk) disable iff (srst)
        setup_valid && is_brk && setup_value != 16'h0 |=> break_active [*8])
        else $error("break ended early");
    a_status_len: assert property (@(posedge sys_clk) disable iff (srst)
        in_valid && kind_q == usbreg_pkg::K_STAT |-> idx_q < 16'h2)
        else $error("status longer than two bytes");
    a_read_count: assert property (@(posedge sys_clk) disable iff (srst)
        in_fire && !setup_valid && idx_nx == len_q |=> ctrl_done && !in_valid)
        else $error("read burst not closed at length");
    a_custom_lat: assert property (@(posedge sys_clk) disable iff (srst)
        wr_cust && ofs == usbreg_pkg::OFS_CUST_LOWLAT |=>
        low_latency == $past(setup_value[0]))
        else $error("low latency bit not updated");
    a_coding_len: assert property (@(posedge sys_clk) disable iff (srst)
        out_ready |-> idx_q < 16'h7)
        else $error("line coding over seven bytes");
    a_fetch_load: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == usbreg_pkg::S_FETCH && !setup_valid ##1 !setup_valid
        |-> ##1 in_valid)
        else $error("read byte not presented in two cycles");

endmodule

// [testbench/usb_host_model.sv]
// Host side of endpoint zero: issues SETUP stages and data stages.
// Assumes the caller serialises requests; outputs move at the rising edge.
`timescale 1ns/10ps
module usb_host_model (
    input wire logic sys_clk,
    output logic setup_valid,
    output logic [7:0] setup_type,
    output logic [7:0] setup_req,
    output logic [15:0] setup_value,
    output logic [15:0] setup_index,
    output logic [15:0] setup_length,
    output logic out_valid,
    output logic [7:0] out_data,
    input wire logic out_ready,
    output logic in_ready
);
    logic slow = 1'b0;
    initial {setup_valid, out_valid, setup_type, setup_req, out_data,
             setup_value, setup_index, setup_length} = 74'h0;
    // A slow host leaves gaps before it takes an IN byte
    always @(posedge sys_clk) in_ready <= !slow || ($urandom % 3 == 0);
    task automatic control(input logic [7:0] t, r,
                           input logic [15:0] v, i, l);
        @(posedge sys_clk);
        setup_valid <= 1'b1;
        {setup_type, setup_req} <= {t, r};
        {setup_value, setup_index, setup_length} <= {v, i, l};
        @(posedge sys_clk);
        // Released fields flip so stale values never pass for data
        setup_valid <= 1'b0;
        {setup_type, setup_req} <= ~{t, r};
        {setup_value, setup_index, setup_length} <= ~{v, i, l};
    endtask
    task automatic send_out(input logic [55:0] b);
        int n;
        logic tk;
        n = 0;
        out_valid <= 1'b1;
        out_data <= b[7:0];
        while (n < 7) begin
            @(negedge sys_clk);
            tk = out_ready;
            @(posedge sys_clk);
            if (tk) begin
                n++;
                out_data <= (n < 7) ? 8'(b >> (8 * n)) : ~out_data;
            end
        end
        out_valid <= 1'b0;
    endtask
endmodule

// [testbench/tb.sv]
// Self-checking bench for the endpoint-zero request decoder.
// Assumes the host model file is compiled first; break unit shortened.
`timescale 1ns/10ps
module tb;
    localparam int BU = 4;
    logic sys_clk, srst, setup_valid, out_valid, out_ready, in_valid;
    logic in_ready, ctrl_done, ctrl_stall, self_powered, remote_wakeup_en;
    logic eep_wr, eep_rd, rx_queue_flush, tx_queue_flush, uart_tx_en;
    logic uart_rx_en, wide_mode, low_latency, irq_packet_en;
    logic dtr, rts, break_active;
    logic [7:0] setup_type, setup_req, out_data, in_data, eep_addr;
    logic [7:0] eep_wdata, eep_rdata, d1, d2, a;
    logic [15:0] setup_value, setup_index, setup_length;
    logic [1:0] queue_gate;
    logic [55:0] lc;
    logic [47:0] bad [6];
    logic [11:0] exp_q [$];
    int err_total = 0;
    int checked = 0;
    int n;
    usb_host_model usb_host_model_i (.sys_clk, .setup_valid, .setup_type,
        .setup_req, .setup_value, .setup_index, .setup_length, .out_valid,
        .out_data, .out_ready, .in_ready);
    usb_vendor_register_access #(.BREAK_UNIT_CYCLES(BU))
    usb_vendor_register_access_i (.sys_clk, .srst, .setup_valid,
        .setup_type, .setup_req, .setup_value, .setup_index, .setup_length,
        .out_valid, .out_data, .out_ready, .in_valid, .in_data, .in_ready,
        .ctrl_done, .ctrl_stall, .self_powered, .remote_wakeup_en, .eep_wr,
        .eep_rd, .eep_addr, .eep_wdata, .eep_rdata, .queue_gate,
        .rx_queue_flush, .tx_queue_flush, .uart_tx_en, .uart_rx_en,
        .wide_mode, .low_latency, .irq_packet_en, .dtr, .rts,
        .break_active);
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // EEPROM stand-in answers only after a read strobe, so a lost one shows
    always @(posedge sys_clk) if (eep_rd) eep_rdata <= eep_addr ^ 8'h5a;
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] got, exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h not %h", $time, what, got,
                     exp);
        end
    endtask
    // Kinds: 1 IN byte, 2 done, 3 stall, 4/5 RX/TX flush, 6/7 EEPROM write
    task automatic note(input logic [11:0] g);
        if (exp_q.size() == 0) chk(g, 12'hfff, "unexpected");
        else chk(g, exp_q.pop_front(), "result");
    endtask
    always @(negedge sys_clk) if (!srst) begin
        if (in_valid && in_ready) note({4'h1, in_data});
        if (rx_queue_flush) note(12'h400);
        if (tx_queue_flush) note(12'h500);
        if (eep_wr) note({4'h6, eep_addr});
        if (eep_wr) note({4'h7, eep_wdata});
        if (ctrl_done) note(12'h200);
        if (ctrl_stall) note(12'h300);
    end
    task automatic ex(input logic [3:0] k, input logic [7:0] d);
        exp_q.push_back({k, d});
    endtask
    task automatic drain();
        int w = 0;
        while (exp_q.size() != 0 && w < 300) begin
            @(posedge sys_clk);
            w++;
        end
        // Each answer that never came counts as a mismatch
        while (exp_q.size() != 0) note(12'hfff);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
    endtask
    task automatic rq(input logic [7:0] t, r, input logic [15:0] v, i, l);
        usb_host_model_i.control(t, r, v, i, l);
        drain();
    endtask
    task automatic vw(input logic [7:0] blk, ofs, val);
        ex(4'h2, 8'h0);
        rq(8'h40, 8'h00, {8'h0, val}, {blk, ofs}, 16'h0);
    endtask
    task automatic vr(input logic [7:0] blk, ofs, input logic [15:0] l);
        ex(4'h2, 8'h0);
        rq(8'hc0, 8'h01, 16'h0, {blk, ofs}, l);
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge sys_clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        complete_run();
    end
    initial begin
        bad = '{48'h4000_0510_0000, 48'h4000_0010_0001, 48'h4007_0000_0000,
                48'h0005_0000_0000, 48'hc001_6700_0001, 48'h8000_0000_0003};
        void'($urandom(32'hd8d35b62));
        {srst, self_powered, remote_wakeup_en} = 3'h4;
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        @(negedge sys_clk);
        chk(12'({queue_gate, uart_tx_en, uart_rx_en, dtr, break_active}),
            12'h0, "reset levels");
        vw(8'h04, 8'h10, 8'h01);
        chk(12'(queue_gate), 12'h1, "gate tx");
        vw(8'h00, 8'h03, 8'h03);
        chk(12'({uart_rx_en, uart_tx_en}), 12'h3, "uart en");
        vw(8'h04, 8'h10, 8'h03);
        chk(12'(queue_gate), 12'h3, "gate rx");
        ex(4'h1, 8'h03);
        vr(8'h04, 8'h10, 16'h1);
        $display("test bring-up ended");
        d1 = 8'($urandom);
        d2 = 8'($urandom);
        vw(8'h00, 8'h1e, d1);
        vw(8'h00, 8'h1f, d2);
        vw(8'h00, 8'h20, 8'hff);
        {usb_host_model_i.slow} = 1'b1;
        ex(4'h1, d1);
        ex(4'h1, d2);
        ex(4'h1, 8'h00);
        vr(8'h00, 8'h1e, 16'h3);
        $display("test burst read ended");
        ex(4'h4, 8'h0);
        vw(8'h04, 8'h18, d1 | 8'h01);
        vw(8'h04, 8'h1c, 8'h00);
        ex(4'h5, 8'h0);
        vw(8'h04, 8'h1c, 8'h80);
        ex(4'h1, 8'h00);
        vr(8'h04, 8'h18, 16'h1);
        $display("test flush ended");
        for (int k = 0; k < 3; k++) vw(8'h66, 8'(k), 8'h01);
        chk(12'({irq_packet_en, low_latency, wide_mode}), 12'h7, "cust");
        for (int k = 0; k < 3; k++) ex(4'h1, 8'h01);
        vr(8'h66, 8'h00, 16'h3);
        a = 8'($urandom);
        ex(4'h6, a);
        ex(4'h7, 8'h5c);
        vw(8'h65, a, 8'h5c);
        ex(4'h1, a ^ 8'h5a);
        ex(4'h1, (a + 8'h01) ^ 8'h5a);
        vr(8'h65, a, 16'h2);
        $display("test blocks ended");
        foreach (bad[k]) begin
            ex(4'h3, 8'h0);
            rq(bad[k][47:40], bad[k][39:32], 16'h0, bad[k][31:16],
               bad[k][15:0]);
        end
        $display("test refusals ended");
        {self_powered, remote_wakeup_en} = 2'($urandom);
        ex(4'h1, {6'h0, remote_wakeup_en, self_powered});
        ex(4'h1, 8'h00);
        ex(4'h2, 8'h0);
        rq(8'h80, 8'h00, 16'h0, 16'h0, 16'h2);
        lc = 56'({$urandom, $urandom});
        ex(4'h2, 8'h0);
        usb_host_model_i.control(8'h21, 8'h20, 16'h0, 16'h0, 16'h7);
        usb_host_model_i.send_out(lc);
        drain();
        chk(12'(out_ready), 12'h0, "coding end");
        for (int k = 0; k < 7; k++) ex(4'h1, 8'(lc >> (8 * k)));
        ex(4'h2, 8'h0);
        rq(8'ha1, 8'h21, 16'h0, 16'h0, 16'h7);
        d1 = 8'($urandom % 4);
        ex(4'h2, 8'h0);
        rq(8'h21, 8'h22, {8'h0, d1}, 16'h0, 16'h0);
        chk(12'({rts, dtr}), 12'(d1), "lines");
        $display("test cdc ended");
        ex(4'h2, 8'h0);
        usb_host_model_i.control(8'h21, 8'h23, 16'h3, 16'h0, 16'h0);
        n = 0;
        @(negedge sys_clk);
        while (break_active && n < 100) begin
            n++;
            @(negedge sys_clk);
        end
        chk(12'(n), 12'(3 * BU), "break length");
        ex(4'h2, 8'h0);
        rq(8'h21, 8'h23, 16'hffff, 16'h0, 16'h0);
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk);
        chk(12'(break_active), 12'h1, "endless break");
        ex(4'h2, 8'h0);
        rq(8'h21, 8'h23, 16'h0, 16'h0, 16'h0);
        chk(12'(break_active), 12'h0, "break ended");
        $display("test break ended");
        complete_run();
    end
endmodule
